// *** issf_pkg.sv ***
// Package: constants, states and the status layout for the slave status flag block
package issf_pkg;
    localparam int         ADDR_W        = 8;
    localparam int         DATA_W        = 32;
    localparam int         BYTE_W        = 8;
    localparam int         ID_NUM        = 4;
    localparam int         TX_DEPTH      = 2;
    localparam int         BIT_LAST      = 7;
    localparam int         BIT_ACK       = 8;
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_RX        = 8'h08;
    localparam logic [7:0] OFS_TX        = 8'h0C;
    localparam logic [7:0] OFS_ALT       = 8'h28;
    localparam logic [7:0] OFS_CFG       = 8'h2C;
    localparam logic [7:0] OFS_ID0       = 8'h38;
    localparam int         CTRL_FLUSH    = 7;
    localparam int         CFG_SLV_EN    = 0;
    localparam int         CFG_GC_EN     = 3;
    localparam int         CFG_HWGC_EN   = 4;
    localparam int         CFG_GC_CLR    = 8;
    localparam logic [7:0] GC_ADDR       = 8'h00;
    localparam logic [7:0] GC_RESET_CMD  = 8'h06;
    localparam logic [7:0] GC_PROG_CMD   = 8'h04;
    localparam logic [1:0] GCT_NONE      = 2'h0;
    localparam logic [1:0] GCT_RESET     = 2'h1;
    localparam logic [1:0] GCT_PROG      = 2'h2;
    localparam logic [1:0] GCT_ALT       = 2'h3;
    localparam logic [31:0] CFG_RESET    = 32'h0;
    localparam logic [7:0] ID_RESET      = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_RX,
        ST_TX,
        ST_GC,
        ST_IGNORE
    } issf_state_t;

    typedef struct packed {
        logic [16:0] reserved;
        logic        start_dec;
        logic        rstart_dec;
        logic [1:0]  match_id;
        logic        stop_irq;
        logic [1:0]  gc_id;
        logic        gc_irq;
        logic        busy;
        logic        no_ack;
        logic        rx_ovf;
        logic        rx_irq;
        logic        tx_irq;
        logic        tx_unf;
        logic        tx_nf;
    } issf_status_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
    } issf_line_ev_t;
endpackage

// *** issf_buf.sv ***
// Two-entry valid/ready buffer used as the slave receive FIFO
`timescale 1ns/1ps
module issf_buf #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    input  wire logic         ref_clk,
    input  wire logic         srst,
    input  wire logic         flush,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0]   count_reg;
    logic          push;
    logic          pop;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready  = (count_reg != (PW + 1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            end
            if (pop) begin
                rd_ptr_reg <= ptr_inc(rd_ptr_reg);
            end
            count_reg <= count_reg + (PW + 1)'(push) - (PW + 1)'(pop);
        end
    end
endmodule

// *** issf_top.sv ***
// Slave channel status flags with line watcher and Avalon-MM register slave
// Overview of operation
// - Match field 12:11 gives which of four ID registers matched, 0 to 3.
// - Bit 10 sets on stop after matched start; status read clears it.
// - Bits 9:8 give general call type: none, reset, program, alternative ID.
// - Bit 7 sets on a reset, program or alternative ID general call; configuration bit 8 write clears it.
// - General call reset returns all interface registers to defaults, except status bits 9:7, which show the reset call.
// - Hardware general call leaves its second byte in receive FIFO.
// - Bit 6 is high while slave channel is in a transfer.
// - Bit 5 sets when master reads with no data; status read clears.
// - Bit 4 sets on receive FIFO overflow; status read clears it.
// - Bit 3 sets per received byte; receive read or flush clears.
// - Bit 2 sets per transmitted byte; transmit write clears it.
// - Bit 1 sets on transmit FIFO underflow; status write clears it.
// - Bit 0 high while transmit FIFO has room; two writes fill it.
// - Bit 14 sets on start plus match; stop or general reset clears.
// - Bit 13 sets on repeated start match; stop, read, reset clear.
// - Address matches on upper seven bits only; direction bit ignored.
//
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module issf_top (
    input  wire logic                         ref_clk,
    input  wire logic                         srst,
    input  wire logic                         scl_in,
    input  wire logic                         sda_in,
    input  wire logic [issf_pkg::ADDR_W-1:0]  avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [issf_pkg::DATA_W-1:0]  avs_writedata,
    input  wire logic [3:0]                   avs_byteenable,
    output logic [issf_pkg::DATA_W-1:0]       avs_readdata,
    output logic                              avs_waitrequest
);
    import issf_pkg::*;

    logic [1:0]         scl_sync_reg;
    logic [1:0]         sda_sync_reg;
    logic               scl_prev_reg;
    logic               sda_prev_reg;
    issf_line_ev_t      ev;
    issf_state_t        state_reg;
    logic [3:0]         bit_cnt_reg;
    logic [BYTE_W-1:0]  shift_reg;
    logic [BYTE_W-1:0]  byte_now;
    logic               byte_done;
    logic               soft_rst;
    logic               rst_all;
    logic               gc_reset_reg;
    issf_status_t       stat_reg;
    issf_status_t       stat_view;
    issf_status_t       snap_reg;
    logic [31:0]        cfg_reg;
    logic [BYTE_W-1:0]  alt_reg;
    logic [BYTE_W-1:0]  id_reg [ID_NUM];
    logic [1:0]         tx_cnt_reg;
    logic               accept;
    logic               wr_acc;
    logic               rd_acc;
    logic               rd_status;
    logic               wr_status;
    logic               wr_tx;
    logic               rd_rx;
    logic               flush;
    logic               rx_push;
    logic               rx_in_ready;
    logic               rx_out_valid;
    logic [BYTE_W-1:0]  rx_out_data;
    logic [BYTE_W-1:0]  rx_push_data;
    logic               addr_hit;
    logic [1:0]         addr_idx;
    logic               tx_consume;
    logic [DATA_W-1:0]  rd_value;

    // Seven-bit compare; the direction bit of both sides is ignored
    function automatic logic id_eq(input logic [7:0] a, input logic [7:0] b);
        return a[7:1] == b[7:1];
    endfunction

    function automatic logic [DATA_W-1:0] widen(input logic [BYTE_W-1:0] v);
        return {{(DATA_W - BYTE_W){1'b0}}, v};
    endfunction

    // Line inputs come from the far clock domain: two flops before any use
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            scl_prev_reg <= scl_sync_reg[1];
            sda_prev_reg <= sda_sync_reg[1];
        end
    end

    always_comb begin
        ev.start    = scl_sync_reg[1] && scl_prev_reg && sda_prev_reg && !sda_sync_reg[1];
        ev.stop     = scl_sync_reg[1] && scl_prev_reg && !sda_prev_reg && sda_sync_reg[1];
        ev.scl_rise = scl_sync_reg[1] && !scl_prev_reg;
    end

    assign byte_now  = {shift_reg[BYTE_W-2:0], sda_sync_reg[1]};
    assign byte_done = ev.scl_rise && (bit_cnt_reg == 4'(BIT_LAST));

    always_comb begin
        addr_hit = 1'b0;
        addr_idx = 2'h0;
        for (int i = ID_NUM - 1; i >= 0; i--) begin
            if (id_eq(byte_now, id_reg[i])) begin
                addr_hit = cfg_reg[CFG_SLV_EN];
                addr_idx = 2'(i);
            end
        end
    end

    // Bus slave: one wait cycle, then the access is taken at the edge with waitrequest low
    assign accept    = (avs_read || avs_write) && !avs_waitrequest;
    assign wr_acc    = accept && avs_write;
    assign rd_acc    = accept && avs_read;
    assign rd_status = rd_acc && (avs_address == OFS_STATUS);
    assign wr_status = wr_acc && (avs_address == OFS_STATUS);
    assign wr_tx     = wr_acc && (avs_address == OFS_TX);
    assign rd_rx     = rd_acc && (avs_address == OFS_RX);
    assign flush     = wr_acc && (avs_address == OFS_CTRL) && avs_writedata[CTRL_FLUSH];
    assign soft_rst  = gc_reset_reg;
    assign rst_all   = srst || soft_rst;

    always_comb begin
        stat_view          = stat_reg;
        stat_view.reserved = '0;
        stat_view.busy     = (state_reg != ST_IDLE) && (state_reg != ST_IGNORE);
        stat_view.tx_nf    = (tx_cnt_reg != 2'(TX_DEPTH));
    end

    always_comb begin
        rd_value = '0;
        if (avs_address == OFS_STATUS) begin
            rd_value = stat_view;
        end else if (avs_address == OFS_RX) begin
            rd_value = widen(rx_out_data);
        end else if (avs_address == OFS_ALT) begin
            rd_value = widen(alt_reg);
        end else if (avs_address == OFS_CFG) begin
            rd_value = cfg_reg;
        end else if (avs_address >= OFS_ID0 && avs_address <= OFS_ID0 + 8'h0C) begin
            rd_value = widen(id_reg[avs_address[3:2] - OFS_ID0[3:2]]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
            snap_reg        <= '0;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? rd_value : '0;
            snap_reg        <= stat_view;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Configuration, alternative ID and ID registers; gc clear bit self-clears
    always_ff @(posedge ref_clk) begin
        if (rst_all) begin
            cfg_reg <= CFG_RESET;
            alt_reg <= ID_RESET;
            for (int i = 0; i < ID_NUM; i++) begin
                id_reg[i] <= ID_RESET;
            end
        end else begin
            cfg_reg[CFG_GC_CLR] <= 1'b0;
            if (wr_acc && avs_byteenable[0] && avs_address == OFS_ALT) begin
                alt_reg <= avs_writedata[BYTE_W-1:0];
            end
            if (wr_acc && avs_address == OFS_CFG) begin
                for (int b = 0; b < 4; b++) begin
                    if (avs_byteenable[b]) begin
                        cfg_reg[b*8 +: 8] <= avs_writedata[b*8 +: 8];
                    end
                end
            end
            for (int i = 0; i < ID_NUM; i++) begin
                if (wr_acc && avs_byteenable[0] && avs_address == OFS_ID0 + 8'(4 * i)) begin
                    id_reg[i] <= avs_writedata[BYTE_W-1:0];
                end
            end
        end
    end

    // Bit counter and shifter; the ninth clock is the acknowledge slot
    always_ff @(posedge ref_clk) begin
        if (rst_all || ev.start || ev.stop) begin
            bit_cnt_reg <= '0;
            shift_reg   <= '0;
        end else if (ev.scl_rise) begin
            shift_reg   <= byte_now;
            bit_cnt_reg <= (bit_cnt_reg == 4'(BIT_ACK)) ? 4'h0 : bit_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst_all || ev.stop) begin
            state_reg <= ST_IDLE;
        end else if (ev.start) begin
            state_reg <= ST_ADDR;
        end else if (byte_done) begin
            case (state_reg)
                ST_ADDR: begin
                    if (addr_hit) begin
                        state_reg <= byte_now[0] ? ST_TX : ST_RX;
                    end else if (byte_now == GC_ADDR && cfg_reg[CFG_GC_EN]) begin
                        state_reg <= ST_GC;
                    end else begin
                        state_reg <= ST_IGNORE;
                    end
                end
                ST_GC: begin
                    state_reg <= ST_RX;
                end
                default: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    // Reset command lands after the status has been marked, then wipes the rest
    always_ff @(posedge ref_clk) begin
        if (srst || gc_reset_reg) begin
            gc_reset_reg <= 1'b0;
        end else begin
            gc_reset_reg <= byte_done && state_reg == ST_GC && byte_now == GC_RESET_CMD;
        end
    end

    // Received bytes, including a hardware general call's second byte, enter the FIFO
    assign rx_push      = byte_done && (state_reg == ST_RX || state_reg == ST_GC);
    assign rx_push_data = byte_now;
    assign tx_consume   = byte_done && state_reg == ST_TX && tx_cnt_reg != 2'h0;

    issf_buf #(
        .W     (BYTE_W),
        .DEPTH (TX_DEPTH)
    ) u_rx_buf (
        .ref_clk   (ref_clk),
        .srst      (rst_all),
        .flush     (flush),
        .in_valid  (rx_push),
        .in_ready  (rx_in_ready),
        .in_data   (rx_push_data),
        .out_valid (rx_out_valid),
        .out_ready (rd_rx),
        .out_data  (rx_out_data)
    );

    // Transmit occupancy only; the written data itself is not stored
    always_ff @(posedge ref_clk) begin
        if (rst_all) begin
            tx_cnt_reg <= '0;
        end else if (wr_tx && !tx_consume && tx_cnt_reg != 2'(TX_DEPTH)) begin
            tx_cnt_reg <= tx_cnt_reg + 2'h1;
        end else if (tx_consume && !wr_tx) begin
            tx_cnt_reg <= tx_cnt_reg - 2'h1;
        end
    end

    // Sticky flags: a status read clears only what the captured read showed, a set always wins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            stat_reg <= '0;
        end else if (soft_rst) begin
            stat_reg        <= '0;
            stat_reg.gc_irq <= 1'b1;
            stat_reg.gc_id  <= GCT_RESET;
        end else begin
            if (rd_status) begin
                stat_reg.stop_irq   <= stat_reg.stop_irq & ~snap_reg.stop_irq;
                stat_reg.no_ack     <= stat_reg.no_ack & ~snap_reg.no_ack;
                stat_reg.rx_ovf     <= stat_reg.rx_ovf & ~snap_reg.rx_ovf;
                stat_reg.rstart_dec <= stat_reg.rstart_dec & ~snap_reg.rstart_dec;
            end
            if (wr_status) begin
                stat_reg.tx_unf <= 1'b0;
            end
            if (rd_rx || flush) begin
                stat_reg.rx_irq <= 1'b0;
            end
            if (wr_tx) begin
                stat_reg.tx_irq <= 1'b0;
            end
            if (cfg_reg[CFG_GC_CLR]) begin
                stat_reg.gc_irq <= 1'b0;
                stat_reg.gc_id  <= GCT_NONE;
            end
            if (ev.stop) begin
                stat_reg.start_dec  <= 1'b0;
                stat_reg.rstart_dec <= 1'b0;
                if (stat_reg.start_dec) begin
                    stat_reg.stop_irq <= 1'b1;
                end
            end
            if (byte_done && state_reg == ST_ADDR && addr_hit) begin
                stat_reg.match_id <= addr_idx;
                if (stat_reg.start_dec) begin
                    stat_reg.rstart_dec <= 1'b1;
                end else begin
                    stat_reg.start_dec <= 1'b1;
                end
                if (byte_now[0] && tx_cnt_reg == 2'h0) begin
                    stat_reg.no_ack <= 1'b1;
                end
            end
            if (byte_done && state_reg == ST_TX) begin
                stat_reg.tx_irq <= 1'b1;
                if (tx_cnt_reg == 2'h0) begin
                    stat_reg.tx_unf <= 1'b1;
                end
            end
            if (rx_push) begin
                stat_reg.rx_irq <= 1'b1;
                if (!rx_in_ready) begin
                    stat_reg.rx_ovf <= 1'b1;
                end
            end
            if (byte_done && state_reg == ST_GC) begin
                if (byte_now == GC_RESET_CMD) begin
                    stat_reg.gc_irq <= 1'b1;
                    stat_reg.gc_id  <= GCT_RESET;
                end else if (byte_now == GC_PROG_CMD) begin
                    stat_reg.gc_irq <= 1'b1;
                    stat_reg.gc_id  <= GCT_PROG;
                end else if (cfg_reg[CFG_HWGC_EN] && byte_now == alt_reg) begin
                    stat_reg.gc_irq <= 1'b1;
                    stat_reg.gc_id  <= GCT_ALT;
                end
            end
        end
    end
endmodule

// *** issf_sva.sv ***
// Checker: bus handshake and flag clearing of the slave status flag block
`timescale 1ns/1ps
module issf_sva import issf_pkg::*; (
    input wire logic                        ref_clk,
    input wire logic                        srst,
    input wire logic                        scl_in,
    input wire logic                        sda_in,
    input wire logic [issf_pkg::ADDR_W-1:0] avs_address,
    input wire logic                        avs_read,
    input wire logic                        avs_write,
    input wire logic [issf_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0]                  avs_byteenable,
    input wire logic [issf_pkg::DATA_W-1:0] avs_readdata,
    input wire logic                        avs_waitrequest
);
    logic [3:0] idle_reg;
    wire acc = !avs_waitrequest && (avs_read || avs_write);
    wire wr = acc && avs_write;
    wire st_rd = acc && avs_read && avs_address == OFS_STATUS;
    // Line idle 15 cycles, so no set can race a clear under check
    wire srd = st_rd && idle_reg == 4'hF;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    always_ff @(posedge ref_clk) begin
        if (srst || !scl_in || !sda_in) begin
            idle_reg <= 4'h0;
        end else if (idle_reg != 4'hF) begin
            idle_reg <= idle_reg + 4'h1;
        end
    end
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    ack_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for two cycles");
    no_spur_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("waitrequest low without request");
    resv_zero_a: assert property (st_rd |-> avs_readdata[31:15] == 17'h0)
        else $error("upper status bits not zero");
    unmap_zero_a: assert property (acc && avs_read && avs_address > 8'h44 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    rd_clr_a: assert property (srd ##[2:4] srd |-> (avs_readdata & 32'h2430) == 32'h0)
        else $error("read clear flag survived status read");
    unf_clr_a: assert property (wr && avs_address == OFS_STATUS ##[2:4] srd |-> !avs_readdata[1])
        else $error("underflow flag survived status write");
    txi_clr_a: assert property (wr && avs_address == OFS_TX ##[2:4] srd |-> !avs_readdata[2])
        else $error("transmit request survived transmit write");
    gc_clr_a: assert property (wr && avs_address == OFS_CFG && avs_writedata[8] ##[2:4] srd
        |-> avs_readdata[9:7] == 3'h0)
        else $error("general call flags survived clear");
    rxi_clr_a: assert property (wr && avs_address == OFS_CTRL && avs_writedata[7] ##[2:4] srd
        |-> !avs_readdata[3])
        else $error("receive request survived flush");
    cover property (srd && avs_readdata[10]);
    cover property (srd && avs_readdata[7]);
    cover property (srd && avs_readdata[4]);
endmodule
bind issf_top issf_sva u_issf_sva (.ref_clk(ref_clk), .srst(srst), .scl_in(scl_in),
    .sda_in(sda_in), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// *** issf_mst.sv ***
// Two-wire bus master model driving the serial lines
`timescale 1ns/1ps
module issf_mst (
    output logic scl,
    output logic sda
);
    // Lines are pulled up: a released line reads high; clock stands high between frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic put(input logic b);
        #40 sda = b;
        #40 scl = 1'b1;
        #80 scl = 1'b0;
    endtask
    task automatic start();
        #40 sda = 1'b1;
        #40 scl = 1'b1;
        #40 sda = 1'b0;
        #40 scl = 1'b0;
    endtask
    task automatic stop();
        #40 sda = 1'b0;
        #40 scl = 1'b1;
        #80 sda = 1'b1;
    endtask
    // Eight bits MSB first, then a released acknowledge slot
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            put(b[i]);
        end
        put(1'b1);
    endtask
endmodule

// *** tb_issf_top.sv ***
// Self-checking bench for the slave status flag block
`timescale 1ns/1ps
module tb_issf_top;
    import issf_pkg::*;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    wire         scl;
    wire         sda;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [31:0] rs = 32'hB8C6;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] e;
    logic [31:0] m;
    logic [7:0]  id;
    logic [7:0]  dat;
    logic [7:0]  alt;
    int          miscompares = 0;
    int          total_checks = 0;
    issf_top u_issf_top (.ref_clk(ref_clk), .srst(srst), .scl_in(scl), .sda_in(sda),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    issf_mst u_issf_mst (.scl(scl), .sda(sda));
    always #10 ref_clk = ~ref_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            miscompares++;
            end_of_test();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [31:0] mv);
        exp_q.push_back(ev & mv);
        msk_q.push_back(mv);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic st(input logic [31:0] ev, input logic [31:0] mv);
        rd(OFS_STATUS, ev, mv);
    endtask
    // Line events start off the clock edge, so the synchroniser never sees a tie
    task automatic ln(input int op, input logic [7:0] b);
        #3;
        case (op)
            0: u_issf_mst.start();
            1: u_issf_mst.send(b);
            default: u_issf_mst.stop();
        endcase
        @(posedge ref_clk);
    endtask
    task automatic xfer(input logic [7:0] a, input logic [7:0] b);
        ln(0, 8'h00);
        ln(1, a);
        ln(1, b);
        ln(2, 8'h00);
        repeat (20) @(posedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            total_checks++;
            if ((avs_readdata & m) !== e) begin
                miscompares++;
                $display("Error t=%0t exp %h got %h", $time, e, avs_readdata & m);
            end
        end
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        miscompares++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        st(32'h1, 32'hFFFFFFFF);
        rd(8'hFC, 32'h0, 32'hFFFFFFFF);
        bus(1'b1, OFS_CFG, 32'h1);
        for (int k = 0; k < 4; k++) begin
            rs = xs(rs);
            id = {1'b1, rs[3:0], k[1:0], 1'b1};
            dat = rs[15:8];
            bus(1'b1, OFS_ID0 + 8'(k * 4), {24'h0, id});
            ln(0, 8'h00);
            ln(1, {id[7:1], 1'b0});
            st(32'h4040 | (32'(k) << 11), 32'h7840);
            ln(1, dat);
            st(32'h8, 32'h8);
            rd(OFS_RX, {24'h0, dat}, 32'hFF);
            st(32'h0, 32'h8);
            ln(0, 8'h00);
            ln(1, {id[7:1], 1'b0});
            st(32'h6040, 32'h6040);
            st(32'h4000, 32'h6000);
            ln(2, 8'h00);
            repeat (20) @(posedge ref_clk);
            st(32'h400, 32'h6440);
            st(32'h0, 32'h400);
        end
        ln(0, 8'h00);
        ln(1, 8'h0E);
        st(32'h0, 32'h6040);
        ln(2, 8'h00);
        $display("test address match done");
        xfer({id[7:1], 1'b1}, 8'hFF);
        st(32'h27, 32'h27);
        bus(1'b1, OFS_STATUS, 32'h0);
        st(32'h5, 32'h27);
        bus(1'b1, OFS_TX, {24'h0, dat});
        st(32'h1, 32'h7);
        bus(1'b1, OFS_TX, {24'h0, ~dat});
        st(32'h0, 32'h1);
        $display("test transmit done");
        ln(0, 8'h00);
        ln(1, {id[7:1], 1'b0});
        ln(1, dat);
        ln(1, ~dat);
        ln(1, 8'h5A);
        xfer(8'h5A, 8'h5A);
        st(32'h18, 32'h18);
        rd(OFS_RX, {24'h0, dat}, 32'hFF);
        rd(OFS_RX, {24'h0, ~dat}, 32'hFF);
        st(32'h0, 32'h18);
        xfer({id[7:1], 1'b0}, dat);
        bus(1'b1, OFS_CTRL, 32'h80);
        st(32'h0, 32'h8);
        $display("test receive done");
        alt = {rs[23:17], 1'b1};
        bus(1'b1, OFS_CFG, 32'h9);
        xfer(GC_ADDR, GC_PROG_CMD);
        st(32'h280, 32'h380);
        st(32'h280, 32'h380);
        rd(OFS_RX, {24'h0, GC_PROG_CMD}, 32'hFF);
        bus(1'b1, OFS_CFG, 32'h109);
        st(32'h0, 32'h380);
        bus(1'b1, OFS_ALT, {24'h0, alt});
        bus(1'b1, OFS_CFG, 32'h119);
        xfer(GC_ADDR, alt);
        st(32'h380, 32'h380);
        rd(OFS_RX, {24'h0, alt}, 32'hFF);
        xfer(GC_ADDR, GC_RESET_CMD);
        st(32'h181, 32'h3FF);
        rd(OFS_CFG, 32'h0, 32'hFFFFFFFF);
        rd(OFS_ID0, 32'h0, 32'hFF);
        $display("test general call done");
        end_of_test();
    end
endmodule
